// ### design/predrv_config_init.sv
// Slew-rate and bias configuration with bootstrap initialization sequencing.
`timescale 1ns/100ps
`default_nettype none
module predrv_config_init
    import predrv_pkg::*;
#(
    parameter int INIT_CYCLES_P = INIT_CYCLES
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    // SPI register port
    input  wire reg_req_t               spi_req,
    output logic [15:0]                 spi_rdata,
    output logic                        spi_rvalid,
    // Microcore register port
    input  wire reg_req_t               mc_req,
    input  wire logic [NUM_OUT-1:0]     output_access_grant,
    // Settings owned by other register files
    input  wire logic [14:0]            vsrc_threshold_prog,
    input  wire logic                   vccp_ext_enable_prog,
    input  wire logic [NUM_HS*NUM_LS-1:0] coupling_select,
    input  wire logic [NUM_HS-1:0]      coupling_disable,
    // Driver commands from the same clock domain
    input  wire logic [NUM_HS-1:0]      hs_on_cmd,
    input  wire logic [NUM_LS-1:0]      ls_on_cmd,
    // Analog and pin inputs
    input  wire hs_fbk_t                hs_fbk,
    input  wire logic                   gate_supply_undervoltage,
    input  wire logic                   debug_strap_pin,
    // Slew-rate settings
    output logic [2*NUM_HS-1:0]         hs_slew,
    output logic [2*(NUM_LS-1)-1:0]     ls_slew,
    output logic [1:0]                  last_low_side_driver_rise,
    output logic [1:0]                  last_low_side_driver_fall,
    // Effective bias and overrides
    output logic [NUM_HS-1:0]           high_pullup_enable,
    output logic [1:0]                  high_strong_pullup_enable,
    output logic [NUM_LS-2:0]           low_pulldown_enable,
    output logic [NUM_HS-1:0]           init_current_limit,
    output logic [14:0]                 vsrc_threshold_eff,
    output logic                        vccp_ext_enable,
    // Bootstrap status
    output logic [NUM_HS-1:0]           boot_cap_uncharged,
    output logic [NUM_HS-1:0]           threshold_raised_flag,
    output logic [NUM_HS-1:0]           low_coupling_active,
    output logic [5:0]                  init_timer_value
);

    localparam int STEP_CYCLES = INIT_CYCLES_P / int'(TIMER_STEPS);

    // Expand one grant bit per output into a two-bit field mask.
    function automatic logic [15:0] pair_mask(input logic [7:0] g);
        logic [15:0] m;
        m = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            m[2*i] = g[i];
            m[2*i+1] = g[i];
        end
        return m;
    endfunction : pair_mask

    // Merge write data into a register under a bit mask.
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [15:0] m);
        return (old & ~m) | (wd & m);
    endfunction : merge

    logic [15:0] hs_slew_reg;
    logic [15:0] ls_slew_reg;
    logic [15:0] bias_reg;

    // Synchronised analog and pin inputs.
    hs_fbk_t     fbk_meta;
    hs_fbk_t     fbk_sync;
    logic        uv_meta;
    logic        uv_sync;
    logic        strap_meta;
    logic        strap_sync;
    logic        strap_latched;

    logic [$clog2(INIT_CYCLES_P+1)-1:0] step_cnt;
    logic [5:0]  step_idx;
    logic        timer_done;

    logic [NUM_HS-1:0] initializing;
    logic [NUM_HS-1:0] thr_high;
    logic [NUM_HS-1:0] exit_req;
    logic        any_init;

    // Register write decode.
    wire spi_hs_wr = spi_req.wr && spi_req.addr == HS_SLEW_ADDR;
    wire spi_ls_wr = spi_req.wr && spi_req.addr == LS_SLEW_ADDR;
    wire spi_bias_wr = spi_req.wr && spi_req.addr == BIAS_CFG_ADDR;
    wire mc_hs_wr = mc_req.wr && mc_req.addr == HS_SLEW_ADDR;
    wire mc_ls_wr = mc_req.wr && mc_req.addr == LS_SLEW_ADDR;
    wire mc_bias_wr = mc_req.wr && mc_req.addr == BIAS_CFG_ADDR;

    // Microcore write masks, one field group per output it holds.
    wire [NUM_HS-1:0] hs_grant = output_access_grant[NUM_HS-1:0];
    wire [NUM_LS-1:0] ls_grant = output_access_grant[NUM_OUT-1:NUM_HS];
    wire [15:0] hs_mask = pair_mask({3'h0, hs_grant}) & 16'h03FF;
    wire [15:0] ls_mask = pair_mask({ls_grant[NUM_LS-1], ls_grant});
    wire [15:0] bias_mask = {3'h0, hs_grant[HS4_IDX], hs_grant[HS2_IDX],
                             ls_grant[NUM_LS-2:0], hs_grant};

    // Reserved bits never store.
    wire [15:0] hs_used_mask = 16'h03FF;
    wire [15:0] bias_used_mask = 16'h1FFF;

    // SPI writes take priority so the host can always recover a setting.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hs_slew_reg <= HS_SLEW_RESET;
            ls_slew_reg <= LS_SLEW_RESET;
            bias_reg <= BIAS_CFG_RESET;
        end else begin
            if (spi_hs_wr) hs_slew_reg <= spi_req.wdata & hs_used_mask;
            else if (mc_hs_wr) hs_slew_reg <= merge(hs_slew_reg, mc_req.wdata, hs_mask);
            if (spi_ls_wr) ls_slew_reg <= spi_req.wdata;
            else if (mc_ls_wr) ls_slew_reg <= merge(ls_slew_reg, mc_req.wdata, ls_mask);
            if (spi_bias_wr) bias_reg <= spi_req.wdata & bias_used_mask;
            else if (mc_bias_wr) bias_reg <= merge(bias_reg, mc_req.wdata, bias_mask);
        end
    end

    // Slew-rate outputs.
    assign hs_slew = hs_slew_reg[HS_SLEW_USED-1:0];
    assign ls_slew = ls_slew_reg[2*(NUM_LS-1)-1:0];
    assign last_low_side_driver_rise = ls_slew_reg[LS7_RISE_LSB+1:LS7_RISE_LSB];
    assign last_low_side_driver_fall = ls_slew_reg[LS7_FALL_LSB+1:LS7_FALL_LSB];

    // Two-flop synchronisers for comparator and pin inputs.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fbk_meta <= '0;
            fbk_sync <= '0;
            uv_meta <= 1'b1;
            uv_sync <= 1'b1;
        end else begin
            fbk_meta <= hs_fbk;
            fbk_sync <= fbk_meta;
            uv_meta <= gate_supply_undervoltage;
            uv_sync <= uv_meta;
        end
    end

    // The strap keeps toggling through its synchroniser during reset so the
    // level present at release is the one held for the rest of operation.
    always_ff @(posedge core_clk) begin
        strap_meta <= debug_strap_pin;
        strap_sync <= strap_meta;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) strap_latched <= strap_sync;
    end

    // Shared initialization timer; held at zero while the supply is low and
    // frozen once expired, so a late dip cannot restart the sequence.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            step_cnt <= '0;
            step_idx <= 6'h00;
        end else if (!timer_done) begin
            if (uv_sync) begin
                step_cnt <= '0;
                step_idx <= 6'h00;
            end else if (step_cnt == ($bits(step_cnt))'(STEP_CYCLES - 1)) begin
                step_cnt <= '0;
                step_idx <= step_idx + 6'h01;
            end else begin
                step_cnt <= step_cnt + 1'b1;
            end
        end
    end

    assign timer_done = (step_idx == TIMER_STEPS);
    assign init_timer_value = step_idx;

    // Low-side coupling indication per high-side source.
    genvar h;
    generate
        for (h = 0; h < NUM_HS; h++) begin : g_hs
            assign low_coupling_active[h] =
                |(coupling_select[h*NUM_LS +: NUM_LS] & ls_on_cmd) | coupling_disable[h];

            assign exit_req[h] = (fbk_sync.bs_ready[h] & fbk_sync.src_below[h])
                               | (fbk_sync.clamp[h] & fbk_sync.src_below[h])
                               | low_coupling_active[h]
                               | hs_on_cmd[h];

            boot_init_channel u_chan (
                .core_clk     (core_clk),
                .sys_rst      (sys_rst),
                .supply_ok    (!uv_sync),
                .timer_done   (timer_done),
                .exit_req     (exit_req[h]),
                .initializing (initializing[h]),
                .thr_high     (thr_high[h]),
                .raised_flag  (threshold_raised_flag[h]),
                .uncharged    (boot_cap_uncharged[h])
            );

            // Override the programmed source threshold only while initializing.
            assign vsrc_threshold_eff[3*h +: 3] =
                !initializing[h] ? vsrc_threshold_prog[3*h +: 3]
                : (thr_high[h] ? VSRC_HIGH_CODE : VSRC_LOW_CODE);
        end
    endgenerate

    assign any_init = |initializing;
    assign init_current_limit = initializing;

    // Effective bias after initialization masks.
    wire [NUM_HS-1:0] hs_pu_prog = bias_reg[BIAS_HS_PU_LSB +: NUM_HS];
    wire [NUM_LS-2:0] ls_pd_prog = bias_reg[BIAS_LS_PD_LSB +: NUM_LS-1];
    assign high_pullup_enable = hs_pu_prog & ~initializing;
    assign high_strong_pullup_enable[0] =
        bias_reg[BIAS_HS2_SPU_BIT] & ~initializing[HS2_IDX];
    assign high_strong_pullup_enable[1] =
        bias_reg[BIAS_HS4_SPU_BIT] & ~initializing[HS4_IDX];
    assign low_pulldown_enable = any_init ? {(NUM_LS-1){1'b1}} : ls_pd_prog;

    wire [15:0] bias_eff = {3'h0, high_strong_pullup_enable[1], high_strong_pullup_enable[0],
                            low_pulldown_enable, high_pullup_enable};

    assign vccp_ext_enable = (any_init && strap_latched) ? 1'b0 : vccp_ext_enable_prog;

    // Register read; unmapped addresses return zero.
    wire [15:0] read_mux =
        (spi_req.addr == HS_SLEW_ADDR) ? hs_slew_reg :
        (spi_req.addr == LS_SLEW_ADDR) ? ls_slew_reg :
        (spi_req.addr == BIAS_CFG_ADDR) ? bias_eff : 16'h0000;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            spi_rdata <= 16'h0000;
            spi_rvalid <= 1'b0;
        end else begin
            spi_rvalid <= spi_req.rd;
            if (spi_req.rd) spi_rdata <= read_mux;
        end
    end

    chk_bias_readback: assert property (@(posedge core_clk) disable iff (sys_rst)
        (spi_req.rd && spi_req.addr == BIAS_CFG_ADDR) |=> spi_rvalid && spi_rdata == $past(bias_eff))
        else $error("bias read did not return effective bias");
    chk_ls_force: assert property (@(posedge core_clk) disable iff (sys_rst)
        any_init |-> low_pulldown_enable == {(NUM_LS-1){1'b1}})
        else $error("low-side pull-downs not forced during initialization");
    chk_hs_mask: assert property (@(posedge core_clk) disable iff (sys_rst)
        (high_pullup_enable & initializing) == '0)
        else $error("high-side pull-up active during initialization");
    chk_bias_restore: assert property (@(posedge core_clk) disable iff (sys_rst)
        !any_init |-> low_pulldown_enable == ls_pd_prog)
        else $error("programmed low-side bias not restored");
    chk_vccp_force: assert property (@(posedge core_clk) disable iff (sys_rst)
        (any_init && strap_latched) |-> !vccp_ext_enable)
        else $error("external regulator enabled during initialization");
    chk_current_limit: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(initializing[0]) |-> !init_current_limit[0] && !boot_cap_uncharged[0])
        else $error("current limit not released with initialization");
    chk_mc_denied: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mc_hs_wr && !spi_req.wr && hs_grant == '0) |=> $stable(hs_slew_reg))
        else $error("microcore changed slew without access");
    chk_timer_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        uv_sync && !timer_done |=> init_timer_value == 6'h00)
        else $error("timer ran during undervoltage");
    chk_threshold_high: assert property (@(posedge core_clk) disable iff (sys_rst)
        thr_high[HS2_IDX] |-> vsrc_threshold_eff[3*HS2_IDX +: 3] == VSRC_HIGH_CODE)
        else $error("raised threshold not applied");

    // Each per-driver check watches a channel that start-up really carries
    // through the state it depends on, so none of them can pass vacuously.
    chk_threshold_low: assert property (@(posedge core_clk) disable iff (sys_rst)
        (initializing[0] && !thr_high[0]) |-> vsrc_threshold_eff[2:0] == VSRC_LOW_CODE)
        else $error("low threshold not applied during initialization");

    chk_threshold_back: assert property (@(posedge core_clk) disable iff (sys_rst)
        !initializing[0] |-> vsrc_threshold_eff[2:0] == vsrc_threshold_prog[2:0])
        else $error("programmed threshold not restored");

    chk_strong_mask: assert property (@(posedge core_clk) disable iff (sys_rst)
        initializing[HS4_IDX] |-> !high_strong_pullup_enable[1])
        else $error("strong pull-up active during initialization");

    chk_pullup_restore: assert property (@(posedge core_clk) disable iff (sys_rst)
        !initializing[2] |-> high_pullup_enable[2] == hs_pu_prog[2])
        else $error("programmed pull-up not restored");

    chk_ls7_split: assert property (@(posedge core_clk) disable iff (sys_rst)
        spi_ls_wr |=> last_low_side_driver_rise == $past(spi_req.wdata[LS7_RISE_LSB +: 2])
                      && last_low_side_driver_fall == $past(spi_req.wdata[LS7_FALL_LSB +: 2]))
        else $error("last low-side edges not stored separately");

    chk_coupling_off: assert property (@(posedge core_clk) disable iff (sys_rst)
        coupling_disable[4] |-> low_coupling_active[4])
        else $error("coupling indication low with coupling disabled");

    chk_timer_frozen: assert property (@(posedge core_clk) disable iff (sys_rst)
        timer_done |=> init_timer_value == TIMER_STEPS)
        else $error("expired timer moved");

    chk_raised_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
        threshold_raised_flag[1] |=> threshold_raised_flag[1])
        else $error("raised flag cleared without reset");

    chk_uncharged_track: assert property (@(posedge core_clk) disable iff (sys_rst)
        boot_cap_uncharged == init_current_limit)
        else $error("uncharged status disagrees with initialization");

    cov_timer_expire: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(timer_done));
    cov_all_done: cover property (@(posedge core_clk) disable iff (sys_rst) $fell(any_init));
    cov_mc_write: cover property (@(posedge core_clk) disable iff (sys_rst)
        mc_bias_wr && bias_mask != 16'h0000);
    cov_coupling_exit: cover property (@(posedge core_clk) disable iff (sys_rst)
        $fell(initializing[HS4_IDX]) && low_coupling_active[HS4_IDX]);

endmodule : predrv_config_init
`default_nettype wire

// ### pkg/predrv_pkg.sv
// Shared constants, carriers and state type for the pre-driver configuration block.
package predrv_pkg;

    localparam int NUM_HS = 5;
    localparam int NUM_LS = 7;
    localparam int NUM_OUT = NUM_HS + NUM_LS;

    // Register offsets (word addresses on the serial register port).
    localparam logic [9:0] HS_SLEW_ADDR = 10'h18E;
    localparam logic [9:0] LS_SLEW_ADDR = 10'h18F;
    localparam logic [9:0] BIAS_CFG_ADDR = 10'h1A4;

    // Reset values.
    localparam logic [15:0] HS_SLEW_RESET = 16'h0000;
    localparam logic [15:0] LS_SLEW_RESET = 16'h0000;
    localparam logic [15:0] BIAS_CFG_RESET = 16'h0000;

    // Field positions.
    localparam int HS_SLEW_USED = 10;
    localparam int LS7_RISE_LSB = 14;
    localparam int LS7_FALL_LSB = 12;
    localparam int BIAS_HS_PU_LSB = 0;
    localparam int BIAS_LS_PD_LSB = 5;
    localparam int BIAS_HS2_SPU_BIT = 11;
    localparam int BIAS_HS4_SPU_BIT = 12;
    localparam int BIAS_USED = 13;
    localparam int HS2_IDX = 1;
    localparam int HS4_IDX = 3;

    // Source threshold codes applied during initialization.
    localparam logic [2:0] VSRC_LOW_CODE = 3'h1;
    localparam logic [2:0] VSRC_HIGH_CODE = 3'h2;

    // Initialization timer: 36 ms at 20 MHz, shown as 52 steps of six bits.
    localparam int INIT_TIME_MS = 36;
    localparam int CLK_HZ = 20_000_000;
    localparam int INIT_CYCLES = INIT_TIME_MS * (CLK_HZ / 1000);
    localparam logic [5:0] TIMER_STEPS = 6'h34;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [9:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [NUM_HS-1:0] bs_ready;
        logic [NUM_HS-1:0] clamp;
        logic [NUM_HS-1:0] src_below;
    } hs_fbk_t;

    typedef enum logic [1:0] {
        WAIT_SUPPLY,
        INIT_LOW,
        INIT_HIGH,
        NORMAL_OP
    } init_state_t;

endpackage : predrv_pkg

// ### design/boot_init_channel.sv
// Bootstrap initialization state machine for one high-side driver.
`timescale 1ns/100ps
`default_nettype none
module boot_init_channel
    import predrv_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // Conditions
    input  wire logic supply_ok,
    input  wire logic timer_done,
    input  wire logic exit_req,
    // Status
    output logic      initializing,
    output logic      thr_high,
    output logic      raised_flag,
    output logic      uncharged
);

    init_state_t state;
    init_state_t next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            WAIT_SUPPLY: if (supply_ok) next_state = INIT_LOW;
            INIT_LOW: begin
                if (exit_req) next_state = NORMAL_OP;
                else if (timer_done) next_state = INIT_HIGH;
            end
            INIT_HIGH: if (exit_req) next_state = NORMAL_OP;
            NORMAL_OP: next_state = NORMAL_OP;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= WAIT_SUPPLY;
            raised_flag <= 1'b0;
        end else begin
            state <= next_state;
            if (state == INIT_LOW && next_state == INIT_HIGH) raised_flag <= 1'b1;
        end
    end

    assign initializing = (state != NORMAL_OP);
    assign thr_high = (state == INIT_HIGH);
    assign uncharged = (state != NORMAL_OP);

    chk_wait_supply: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == WAIT_SUPPLY && !supply_ok) |=> state == WAIT_SUPPLY)
        else $error("init left before supply was good");
    chk_timer_raise: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == INIT_LOW && timer_done && !exit_req) |=> (thr_high && raised_flag))
        else $error("threshold not raised at end of count");
    chk_exit_init: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state inside {INIT_LOW, INIT_HIGH} && exit_req) |=> !initializing && !uncharged)
        else $error("driver stayed in initialization after exit condition");
    chk_normal_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
        !initializing |=> !initializing [*2])
        else $error("driver re-entered initialization");
    cov_high_path: cover property (@(posedge core_clk) disable iff (sys_rst)
        thr_high ##1 !initializing);

endmodule : boot_init_channel
`default_nettype wire

// ### tb/comparator_model.sv
// Behavioural model of the supply monitor and bootstrap comparators beside the block.
`timescale 1ns/100ps
`default_nettype none
module comparator_model
    import predrv_pkg::*;
#(
    parameter int SLOW_CYCLES = 20
) (
    // Clock
    input  wire logic              core_clk,
    // Scenario controls
    input  wire logic              supply_on,
    input  wire logic              slow,
    input  wire logic [NUM_HS-1:0] charge_go,
    input  wire logic [NUM_HS-1:0] clamp_go,
    // Comparator outputs
    output var logic               uv,
    output var hs_fbk_t            fbk
);
    logic [4:0] cnt;
    logic       ready_now;

    // A slow capacitor takes many cycles to charge, so the ready edge can arrive late.
    assign ready_now = (cnt >= (slow ? 5'(SLOW_CYCLES) : 5'h02));

    always_ff @(posedge core_clk) begin
        uv <= !supply_on;
        if (charge_go == '0) begin
            cnt <= 5'h00;
        end else if (cnt != 5'h1F) begin
            cnt <= cnt + 5'h01;
        end
        fbk.bs_ready  <= charge_go & {NUM_HS{ready_now}};
        fbk.clamp     <= clamp_go;
        // The source node sits low only while its switch is charging or clamped.
        fbk.src_below <= charge_go | clamp_go;
    end
endmodule : comparator_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the pre-driver configuration and bootstrap sequencing block.
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import predrv_pkg::*;
;
    logic                       core_clk = 1'b0;
    logic                       sys_rst  = 1'b1;
    reg_req_t                   spi_req  = '0;
    reg_req_t                   mc_req   = '0;
    logic [NUM_OUT-1:0]         grant    = '0;
    logic [14:0]                vprog    = '0;
    logic [NUM_HS*NUM_LS-1:0]   csel     = '0;
    logic [NUM_HS-1:0]          cdis     = '0;
    logic [NUM_HS-1:0]          hs_on    = '0;
    logic [NUM_HS-1:0]          chg      = '0;
    logic [NUM_HS-1:0]          clp      = '0;
    logic [NUM_LS-1:0]          ls_on    = '0;
    logic                       supply_on = 1'b0;
    logic                       slow     = 1'b0;
    logic                       strap    = 1'b1;
    hs_fbk_t                    fbk;
    logic                       uv;
    logic [15:0]                rdata;
    logic                       rvalid;
    logic [9:0]                 hs_slew;
    logic [11:0]                ls_slew;
    logic [1:0]                 lr;
    logic [1:0]                 lf;
    logic [4:0]                 hpu;
    logic [1:0]                 hspu;
    logic [5:0]                 lpd;
    logic [4:0]                 icl;
    logic [14:0]                veff;
    logic                       vext;
    logic [4:0]                 unch;
    logic [4:0]                 raised;
    logic [4:0]                 lca;
    logic [5:0]                 tval;
    logic [15:0]                exp_q[$];
    int                         fails = 0;
    int                         n_compared = 0;

    always #25 core_clk = ~core_clk;

    comparator_model PARTNER (.core_clk(core_clk), .supply_on(supply_on), .slow(slow),
        .charge_go(chg), .clamp_go(clp), .uv(uv), .fbk(fbk));

    predrv_config_init #(.INIT_CYCLES_P(520)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
        .spi_req(spi_req), .spi_rdata(rdata), .spi_rvalid(rvalid), .mc_req(mc_req),
        .output_access_grant(grant), .vsrc_threshold_prog(vprog),
        .vccp_ext_enable_prog(1'b1), .coupling_select(csel), .coupling_disable(cdis),
        .hs_on_cmd(hs_on), .ls_on_cmd(ls_on), .hs_fbk(fbk), .gate_supply_undervoltage(uv),
        .debug_strap_pin(strap), .hs_slew(hs_slew), .ls_slew(ls_slew),
        .last_low_side_driver_rise(lr), .last_low_side_driver_fall(lf),
        .high_pullup_enable(hpu), .high_strong_pullup_enable(hspu),
        .low_pulldown_enable(lpd), .init_current_limit(icl), .vsrc_threshold_eff(veff),
        .vccp_ext_enable(vext), .boot_cap_uncharged(unch), .threshold_raised_flag(raised),
        .low_coupling_active(lca), .init_timer_value(tval));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    // One access: driven at a falling edge, taken at the next rising edge, then released.
    task automatic req(input logic mc, input logic wr, input logic [9:0] a, input logic [15:0] d);
        reg_req_t r;
        r = '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(negedge core_clk);
        if (mc) mc_req = r;
        else spi_req = r;
        @(negedge core_clk);
        spi_req = '0;
        mc_req = '0;
    endtask : req

    task automatic rd(input logic [9:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        req(1'b0, 1'b0, a, 16'h0000);
    endtask : rd

    // Read data is a one-cycle pulse, so it is matched against the oldest note at once.
    always @(posedge core_clk) begin
        if (rvalid === 1'b1) begin
            check(rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hDEAD);
        end
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        end_of_test();
    end

    initial begin
        logic [15:0] dh;
        logic [15:0] dl;
        int          n;
        void'($urandom(95270));
        cyc(20);
        sys_rst = 1'b0;
        check(16'(icl), 16'h001F);
        check(16'(unch), 16'h001F);
        check(16'(vext), 16'h0000);
        check(16'(veff), 16'h1249);
        rd(HS_SLEW_ADDR, HS_SLEW_RESET);
        rd(LS_SLEW_ADDR, LS_SLEW_RESET);
        rd(BIAS_CFG_ADDR, 16'h07E0);
        rd(10'h3FF, 16'h0000);
        $display("test reset done");
        dh = 16'($urandom);
        dl = 16'($urandom);
        req(1'b0, 1'b1, HS_SLEW_ADDR, dh);
        req(1'b0, 1'b1, LS_SLEW_ADDR, dl);
        rd(HS_SLEW_ADDR, dh & 16'h03FF);
        rd(LS_SLEW_ADDR, dl);
        check({lr, lf, ls_slew}, dl);
        grant = 12'h801;
        req(1'b1, 1'b1, HS_SLEW_ADDR, 16'hFFFF);
        req(1'b1, 1'b1, LS_SLEW_ADDR, 16'h0000);
        grant = 12'h000;
        req(1'b1, 1'b1, HS_SLEW_ADDR, 16'h0000);
        cyc(2);
        check(16'(hs_slew), {6'h00, dh[9:2], 2'b11});
        check({lr, lf, ls_slew}, {4'h0, dl[11:0]});
        $display("test slew done");
        vprog = 15'($urandom);
        // Sources here are not shared, so pull-ups may be programmed before init ends.
        req(1'b0, 1'b1, BIAS_CFG_ADDR, 16'h0015);
        supply_on = 1'b1;
        cyc(8);
        hs_on[0] = 1'b1;
        cyc(6);
        check(16'(unch), 16'h001E);
        check(16'(icl), 16'h001E);
        check(16'(hpu), 16'h0001);
        check(16'(veff), 16'({{4{VSRC_LOW_CODE}}, vprog[2:0]}));
        n = 14;
        while (raised === 5'h00 && n < 1000) begin
            cyc(1);
            n++;
        end
        check(16'(n > 500 && n < 540), 16'h0001);
        check(16'(raised), 16'h001E);
        check(16'(tval), 16'(TIMER_STEPS));
        check(16'(veff), 16'({{4{VSRC_HIGH_CODE}}, vprog[2:0]}));
        for (int i = 1; i < 5; i++) begin
            case (i)
                1: begin
                    slow = 1'b1;
                    chg[1] = 1'b1;
                end
                2: clp[2] = 1'b1;
                3: begin
                    csel[21] = 1'b1;
                    ls_on[0] = 1'b1;
                end
                default: begin
                    check(16'(lpd), 16'h003F);
                    check(16'(vext), 16'h0000);
                    cdis[4] = 1'b1;
                end
            endcase
            cyc(30);
            check(16'(unch), 16'(5'(5'h1F << (i + 1))));
        end
        check(16'(lca), 16'h0018);
        check(16'(icl), 16'h0000);
        check(16'(veff), 16'(vprog));
        check(16'(vext), 16'h0001);
        check(16'(lpd), 16'h0000);
        req(1'b0, 1'b1, BIAS_CFG_ADDR, 16'h1815);
        rd(BIAS_CFG_ADDR, 16'h1815);
        check(16'(hspu), 16'h0003);
        check(16'(hpu), 16'h0015);
        check(16'(raised), 16'h001E);
        grant = 12'h002;
        req(1'b1, 1'b1, BIAS_CFG_ADDR, 16'h0000);
        rd(BIAS_CFG_ADDR, 16'h1015);
        check(16'(hspu), 16'h0002);
        $display("test init done");
        strap = 1'b0;
        supply_on = 1'b0;
        sys_rst = 1'b1;
        cyc(4);
        sys_rst = 1'b0;
        check(16'(vext), 16'h0001);
        check(16'(raised), 16'h0000);
        rd(BIAS_CFG_ADDR, 16'h07E0);
        $display("test strap done");
        cyc(3);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
